// >>> src/strap_cfg.sv
`timescale 1ns/1ps
module strap_cfg
  import ser_cfg_pkg::*;
(
  // system clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // strap and power pins (asynchronous)
  input wire ser_cfg_pkg::strap_t i_straps,
  input wire logic i_lane_width_select,
  input wire logic i_power_down_n,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // configuration results
  output logic o_powered_down,
  output logic o_link_start,
  output logic o_range_detect,
  output logic o_ctrl_remote,
  output ser_cfg_pkg::ctrl_mode_t o_ctrl_mode,
  output logic [16:0] o_rate_min_khz,
  output logic [16:0] o_rate_max_khz,
  // link clock domain
  input wire logic i_lvds_input_clock,
  input wire logic [ser_cfg_pkg::NUM_LANES*ser_cfg_pkg::LANE_BITS-1:0] i_lanes,
  input wire logic [1:0] i_aux_control_inputs,
  input wire logic i_audio_or_ctrl0_input,
  output logic [ser_cfg_pkg::DIN_W-1:0] o_word,
  output logic [ser_cfg_pkg::DIN_W-1:0] o_crypt_mask,
  output logic o_audio_bit,
  output logic o_audio_crypt,
  output logic o_ctrl0_bit
);
  import ser_cfg_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] dev_addr(input logic [1:0] hi, input logic [1:0] lo,
                                          input logic far);
    logic [2:0] h;
    logic [1:0] l;
    h = (hi == LVL_LOW) ? ADDR_HI_LOW : (hi == LVL_HIGH) ? ADDR_HI_HIGH : ADDR_HI_OPEN;
    l = (lo == LVL_LOW) ? ADDR_LO_LOW : (lo == LVL_HIGH) ? ADDR_LO_HIGH : ADDR_LO_OPEN;
    dev_addr = {h, far, l, 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  strap_t strap_s;
  logic bws_s;
  logic pdn_s;

  sync2 #(.W($bits(strap_t) + 2)) u_pin_sync (
    .i_clk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_straps, i_lane_width_select, i_power_down_n}),
    .o_q({strap_s, bws_s, pdn_s})
  );

  // ----------------------------------------------------------------
  // capture at power-up and on leaving power-down
  // ----------------------------------------------------------------
  logic [START_SYNC_CYCLES:0] start_q;
  logic pdn_q;
  logic capture;
  strap_t cap_q;

  // wait until the synchronisers hold real pin levels before the first capture
  assign capture = (start_q[START_SYNC_CYCLES-1] & ~start_q[START_SYNC_CYCLES])
                   | (pdn_s & ~pdn_q & start_q[0]);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      start_q <= '0;
      pdn_q <= 1'b0;
    end else begin
      start_q <= {start_q[START_SYNC_CYCLES-1:0], 1'b1};
      pdn_q <= pdn_s;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cap_q <= '0;
    end else if (capture) begin
      cap_q <= strap_s;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] addr_a_q;
  logic [7:0] addr_b_q;
  logic [7:0] link_ctrl_q;
  logic [7:0] bit_map_q;
  logic [7:0] stat_w;
  logic [7:0] rd_mux;
  logic wr_a;
  logic wr_b;
  logic wr_ctrl;
  logic wr_map;

  assign wr_a = i_reg_wr & (i_reg_addr == REG_DEV_ADDR_A);
  assign wr_b = i_reg_wr & (i_reg_addr == REG_DEV_ADDR_B);
  assign wr_ctrl = i_reg_wr & (i_reg_addr == REG_LINK_CTRL);
  assign wr_map = i_reg_wr & (i_reg_addr == REG_BIT_MAP);
  assign stat_w = {cap_q.rate_range_select, cap_q.controller_side_select,
                   cap_q.link_mode_select, cap_q.auto_link_start_n, bws_s,
                   o_powered_down, 2'h0};
  assign rd_mux = (i_reg_addr == REG_DEV_ADDR_A) ? addr_a_q :
                  (i_reg_addr == REG_DEV_ADDR_B) ? addr_b_q :
                  (i_reg_addr == REG_LINK_CTRL) ? link_ctrl_q :
                  (i_reg_addr == REG_STRAP_STAT) ? stat_w :
                  (i_reg_addr == REG_BIT_MAP) ? bit_map_q : 8'h00;

  // a strap capture overrides a write in the same cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      addr_a_q <= 8'h00;
      addr_b_q <= 8'h00;
    end else if (capture) begin
      addr_a_q <= dev_addr(strap_s.addr_strap_high, strap_s.addr_strap_low, 1'b0);
      addr_b_q <= dev_addr(strap_s.addr_strap_high, strap_s.addr_strap_low, 1'b1);
    end else begin
      if (wr_a) begin
        addr_a_q <= i_reg_wdata;
      end
      if (wr_b) begin
        addr_b_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      link_ctrl_q <= LINK_CTRL_RST;
      bit_map_q <= BIT_MAP_RST;
      o_reg_rdata <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        link_ctrl_q <= i_reg_wdata;
      end
      if (wr_map) begin
        bit_map_q <= i_reg_wdata;
      end
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  logic [16:0] rmin_w;
  logic [16:0] rmax_w;

  assign rmin_w = cap_q.rate_range_select ?
                  (bws_s ? RATE_SLOW_4L_MIN : RATE_SLOW_3L_MIN) :
                  (bws_s ? RATE_FAST_4L_MIN : RATE_FAST_3L_MIN);
  assign rmax_w = cap_q.rate_range_select ?
                  (bws_s ? RATE_SLOW_4L_MAX : RATE_SLOW_3L_MAX) :
                  (bws_s ? RATE_FAST_4L_MAX : RATE_FAST_3L_MAX);

  // control channel itself (full duplex, UART_MIN_BPS..UART_MAX_BPS) lives elsewhere;
  // this block only tells it which framing to use
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_powered_down <= 1'b1;
      o_link_start <= 1'b0;
      o_range_detect <= 1'b0;
      o_ctrl_remote <= 1'b0;
      o_ctrl_mode <= CTRL_BASE;
      o_rate_min_khz <= 17'h0;
      o_rate_max_khz <= 17'h0;
    end else begin
      o_powered_down <= ~pdn_s;
      o_link_start <= pdn_s & start_q[START_SYNC_CYCLES] & ~cap_q.auto_link_start_n;
      o_range_detect <= pdn_s & start_q[START_SYNC_CYCLES] & ~cap_q.auto_link_start_n;
      o_ctrl_remote <= cap_q.controller_side_select;
      o_ctrl_mode <= cap_q.link_mode_select ? CTRL_BYPASS : CTRL_BASE;
      o_rate_min_khz <= rmin_w;
      o_rate_max_khz <= rmax_w;
    end
  end

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  link_cfg_t cfg_m;
  link_cfg_t cfg_l;

  assign cfg_m = '{four_lane: bws_s,
                   crypt_en: link_ctrl_q[BIT_CRYPT_EN],
                   audio_channel_on: link_ctrl_q[BIT_AUDIO_ON],
                   reserved_bit_disable: bit_map_q[BIT_RES_DIS]};

  // quasi-static levels; one may lag another by one link cycle after a change
  sync2 #(.W($bits(link_cfg_t))) u_cfg_sync (
    .i_clk(i_lvds_input_clock),
    .i_rst(i_rst),
    .i_d(cfg_m),
    .o_q(cfg_l)
  );

  logic [DIN_W-1:0] word_w;
  logic [DIN_W-1:0] mask_w;

  generate
    for (genvar b = 0; b < DIN_W; b++) begin : g_map
      if (b < BITS_3LANE) begin : g_base
        assign word_w[b] = i_lanes[b];
        assign mask_w[b] = cfg_l.crypt_en & (b < COLOR_BASE_BITS);
      end else if (b <= COLOR_EXT_HI) begin : g_ext
        assign word_w[b] = cfg_l.four_lane & i_lanes[b];
        assign mask_w[b] = cfg_l.crypt_en & cfg_l.four_lane & (b >= COLOR_EXT_LO);
      end else if (b == DIN_RES) begin : g_res
        assign word_w[b] = cfg_l.four_lane &
                           (cfg_l.reserved_bit_disable ? i_aux_control_inputs[0]
                                                       : i_lanes[b]);
        assign mask_w[b] = 1'b0;
      end else begin : g_cntl2
        assign word_w[b] = cfg_l.four_lane & i_aux_control_inputs[1];
        assign mask_w[b] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge i_lvds_input_clock or posedge i_rst) begin
    if (i_rst) begin
      o_word <= '0;
      o_crypt_mask <= '0;
      o_audio_bit <= 1'b0;
      o_audio_crypt <= 1'b0;
      o_ctrl0_bit <= 1'b0;
    end else begin
      o_word <= word_w;
      o_crypt_mask <= mask_w;
      o_audio_bit <= cfg_l.audio_channel_on & i_audio_or_ctrl0_input;
      o_audio_crypt <= cfg_l.audio_channel_on & cfg_l.crypt_en;
      o_ctrl0_bit <= ~cfg_l.audio_channel_on & i_audio_or_ctrl0_input;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_strap_hold;
    @(posedge i_mclk) disable iff (i_rst) !capture |=> $stable(cap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap latch moved");

  property p_rate_cap;
    @(posedge i_mclk) disable iff (i_rst)
      capture |=> cap_q.rate_range_select == $past(strap_s.rate_range_select);
  endproperty
  a_rate_cap: assert property (p_rate_cap) else $error("rate strap not captured");

  property p_addr_cap;
    @(posedge i_mclk) disable iff (i_rst)
      capture |=> addr_a_q[7:5] != 3'h0 && addr_a_q[4] == 1'b0 && addr_b_q[4] == 1'b1
                  && addr_a_q[1:0] == 2'h0;
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("address decode wrong");

  property p_addr_wr;
    @(posedge i_mclk) disable iff (i_rst)
      wr_a && !capture |=> addr_a_q == $past(i_reg_wdata)
                           ##1 ($stable(addr_a_q) || $past(capture) || $past(wr_a));
  endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("address write lost");

  property p_pd;
    @(posedge i_mclk) disable iff (i_rst)
      !pdn_s |=> o_powered_down && !o_link_start;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not honoured");

  property p_autostart;
    @(posedge i_mclk) disable iff (i_rst)
      cap_q.auto_link_start_n |=> !o_link_start || $past(capture);
  endproperty
  a_autostart: assert property (p_autostart) else $error("link started without autostart");

  property p_three_lane;
    @(posedge i_lvds_input_clock) disable iff (i_rst)
      !cfg_l.four_lane |=> o_word[DIN_W-1:BITS_3LANE] == '0
                           && o_word[BITS_3LANE-1:0] == $past(i_lanes[BITS_3LANE-1:0]);
  endproperty
  a_three_lane: assert property (p_three_lane) else $error("lane four leaked");

  property p_res_bit;
    @(posedge i_lvds_input_clock) disable iff (i_rst)
      cfg_l.four_lane && cfg_l.reserved_bit_disable
      |=> o_word[DIN_RES] == $past(i_aux_control_inputs[0]);
  endproperty
  a_res_bit: assert property (p_res_bit) else $error("bit 27 not aux control");

  property p_ext_crypt;
    @(posedge i_lvds_input_clock) disable iff (i_rst)
      cfg_l.four_lane && cfg_l.crypt_en
      |=> &o_crypt_mask[COLOR_EXT_HI:COLOR_EXT_LO] && &o_crypt_mask[COLOR_BASE_BITS-1:0];
  endproperty
  a_ext_crypt: assert property (p_ext_crypt) else $error("colour bits not encrypted");

  property p_clear_bits;
    @(posedge i_lvds_input_clock) disable iff (i_rst)
      o_crypt_mask[DIN_CNTL2:DIN_RES] == 2'h0
      && o_crypt_mask[BITS_3LANE-1:COLOR_BASE_BITS] == 3'h0;
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("control bit encrypted");

  c_capture: cover property (@(posedge i_mclk) disable iff (i_rst)
                             capture && pdn_s && !pdn_q && start_q[START_SYNC_CYCLES]);
  c_addr_wr: cover property (@(posedge i_mclk) disable iff (i_rst) wr_b);
  c_res_map: cover property (@(posedge i_lvds_input_clock) disable iff (i_rst)
                             cfg_l.four_lane && cfg_l.reserved_bit_disable);
  c_ctrl0: cover property (@(posedge i_lvds_input_clock) disable iff (i_rst) o_ctrl0_bit);
endmodule

// >>> include/ser_cfg_pkg.sv
package ser_cfg_pkg;

  // ----------------------------------------------------------------
  // register map (index = byte offset, 8-bit registers)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DEV_ADDR_A = 8'h00;
  localparam logic [7:0] REG_DEV_ADDR_B = 8'h01;
  localparam logic [7:0] REG_LINK_CTRL = 8'h04;
  localparam logic [7:0] REG_STRAP_STAT = 8'h05;
  localparam logic [7:0] REG_BIT_MAP = 8'h0d;

  localparam int BIT_RES_DIS = 4;
  localparam int BIT_CRYPT_EN = 0;
  localparam int BIT_AUDIO_ON = 1;
  localparam logic [7:0] LINK_CTRL_RST = 8'h02;
  localparam logic [7:0] BIT_MAP_RST = 8'h00;

  // ----------------------------------------------------------------
  // three-level strap codes and address fields
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [2:0] ADDR_HI_LOW = 3'h4;
  localparam logic [2:0] ADDR_HI_HIGH = 3'h6;
  localparam logic [2:0] ADDR_HI_OPEN = 3'h2;
  localparam logic [1:0] ADDR_LO_LOW = 2'h0;
  localparam logic [1:0] ADDR_LO_HIGH = 2'h1;
  localparam logic [1:0] ADDR_LO_OPEN = 2'h2;

  // ----------------------------------------------------------------
  // lane layout
  // ----------------------------------------------------------------
  localparam int LANE_BITS = 7;
  localparam int NUM_LANES = 4;
  localparam int DIN_W = 29;
  localparam int BITS_3LANE = 21;
  localparam int COLOR_BASE_BITS = 18;
  localparam int COLOR_EXT_LO = 21;
  localparam int COLOR_EXT_HI = 26;
  localparam int DIN_RES = 27;
  localparam int DIN_CNTL2 = 28;

  // ----------------------------------------------------------------
  // timing and rate limits (kHz, bps)
  // ----------------------------------------------------------------
  localparam int START_SYNC_CYCLES = 2;
  localparam logic [16:0] RATE_SLOW_3L_MIN = 17'd8330;
  localparam logic [16:0] RATE_SLOW_3L_MAX = 17'd16660;
  localparam logic [16:0] RATE_SLOW_4L_MIN = 17'd6250;
  localparam logic [16:0] RATE_SLOW_4L_MAX = 17'd12500;
  localparam logic [16:0] RATE_FAST_3L_MIN = 17'd16660;
  localparam logic [16:0] RATE_FAST_3L_MAX = 17'd104000;
  localparam logic [16:0] RATE_FAST_4L_MIN = 17'd12500;
  localparam logic [16:0] RATE_FAST_4L_MAX = 17'd78000;
  localparam int UART_MIN_BPS = 9600;
  localparam int UART_MAX_BPS = 1000000;
  localparam int AUDIO_MIN_HZ = 8000;
  localparam int AUDIO_MAX_HZ = 192000;
  localparam int AUDIO_MIN_WORD = 4;
  localparam int AUDIO_MAX_WORD = 32;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rate_range_select;
    logic [1:0] addr_strap_high;
    logic [1:0] addr_strap_low;
    logic controller_side_select;
    logic link_mode_select;
    logic auto_link_start_n;
  } strap_t;

  typedef struct packed {
    logic four_lane;
    logic crypt_en;
    logic audio_channel_on;
    logic reserved_bit_disable;
  } link_cfg_t;

  typedef enum logic {CTRL_BASE, CTRL_BYPASS} ctrl_mode_t;

endpackage

// >>> src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // level in and out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule

// >>> tb/lvds_source.sv
`timescale 1ns/1ps
module lvds_source
  import ser_cfg_pkg::*;
(
  // link clock and enable
  input wire logic i_clk,
  input wire logic i_run,
  // lane, aux and audio pins
  output logic [ser_cfg_pkg::NUM_LANES*ser_cfg_pkg::LANE_BITS-1:0] o_lanes,
  output logic [1:0] o_aux,
  output logic o_sd
);
  // ----------------------------------------------------------------
  // source
  // ----------------------------------------------------------------
  initial begin
    o_lanes = '0;
    o_aux = 2'h0;
    o_sd = 1'b0;
  end

  // new data on the falling edge so the capturing rising edge sees settled levels
  always @(negedge i_clk) begin
    if (i_run) begin
      o_lanes <= (NUM_LANES*LANE_BITS)'($urandom);
      o_aux <= 2'($urandom);
      o_sd <= 1'($urandom);
    end
  end
endmodule

// >>> tb/strap_cfg_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module strap_cfg_bench;
  import ser_cfg_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_mclk, i_rst, i_lane_width_select, i_power_down_n, i_reg_wr, i_reg_rd;
  strap_t i_straps;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic o_powered_down, o_link_start, o_range_detect, o_ctrl_remote;
  ctrl_mode_t o_ctrl_mode;
  logic [16:0] o_rate_min_khz, o_rate_max_khz;
  logic i_lvds_input_clock, i_audio_or_ctrl0_input, o_audio_bit, o_audio_crypt, o_ctrl0_bit;
  logic [NUM_LANES*LANE_BITS-1:0] i_lanes;
  logic [1:0] i_aux_control_inputs;
  logic [DIN_W-1:0] o_word, o_crypt_mask;
  logic src_run;
  int err_count, num_checks;
  int reg_m [int];
  strap_t cap_m;

  strap_cfg dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_straps(i_straps),
    .i_lane_width_select(i_lane_width_select), .i_power_down_n(i_power_down_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_powered_down(o_powered_down),
    .o_link_start(o_link_start), .o_range_detect(o_range_detect),
    .o_ctrl_remote(o_ctrl_remote), .o_ctrl_mode(o_ctrl_mode),
    .o_rate_min_khz(o_rate_min_khz), .o_rate_max_khz(o_rate_max_khz),
    .i_lvds_input_clock(i_lvds_input_clock), .i_lanes(i_lanes),
    .i_aux_control_inputs(i_aux_control_inputs),
    .i_audio_or_ctrl0_input(i_audio_or_ctrl0_input), .o_word(o_word),
    .o_crypt_mask(o_crypt_mask), .o_audio_bit(o_audio_bit),
    .o_audio_crypt(o_audio_crypt), .o_ctrl0_bit(o_ctrl0_bit));

  lvds_source src (.i_clk(i_lvds_input_clock), .i_run(src_run), .o_lanes(i_lanes),
    .o_aux(i_aux_control_inputs), .o_sd(i_audio_or_ctrl0_input));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // link clock unrelated in phase to the system clock
  initial begin
    i_lvds_input_clock = 1'b0;
    #17;
    forever #32 i_lvds_input_clock = ~i_lvds_input_clock;
  end

  // ----------------------------------------------------------------
  // model
  // ----------------------------------------------------------------
  function automatic logic [7:0] addr_of(logic [1:0] hi, logic [1:0] lo, logic x);
    logic [2:0] h;
    logic [1:0] l;
    h = (hi == 2'h0) ? 3'b100 : (hi == 2'h1) ? 3'b110 : 3'b010;
    l = (lo == 2'h0) ? 2'b00 : (lo == 2'h1) ? 2'b01 : 2'b10;
    return {h, x, l, 2'b00};
  endfunction

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    if (reg_m.exists(a)) reg_m[a] = d;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    `CHK(o_reg_rdata, e)
  endtask

  task automatic chk_cfg;
    int mn, mx;
    case ({cap_m.rate_range_select, i_lane_width_select})
      2'b10: begin mn = 8330; mx = 16660; end
      2'b11: begin mn = 6250; mx = 12500; end
      2'b00: begin mn = 16660; mx = 104000; end
      default: begin mn = 12500; mx = 78000; end
    endcase
    `CHK(o_powered_down, 1'b0)
    `CHK(o_ctrl_remote, cap_m.controller_side_select)
    `CHK(o_ctrl_mode, cap_m.link_mode_select ? CTRL_BYPASS : CTRL_BASE)
    `CHK(o_link_start, ~cap_m.auto_link_start_n)
    `CHK(o_range_detect, ~cap_m.auto_link_start_n)
    `CHK(o_rate_min_khz, 17'(mn))
    `CHK(o_rate_max_khz, 17'(mx))
    reg_chk(8'h00, 8'(reg_m[0]));
    reg_chk(8'h01, 8'(reg_m[1]));
    reg_chk(8'h05, {cap_m.rate_range_select, cap_m.controller_side_select,
      cap_m.link_mode_select, cap_m.auto_link_start_n, i_lane_width_select, 3'b000});
  endtask

  task automatic capture(input strap_t s);
    @(negedge i_mclk);
    i_power_down_n = 1'b0;
    repeat (6) @(negedge i_mclk);
    `CHK(o_powered_down, 1'b1)
    `CHK(o_link_start, 1'b0)
    i_straps = s;
    i_power_down_n = 1'b1;
    repeat (10) @(negedge i_mclk);
    cap_m = s;
    reg_m[0] = addr_of(s.addr_strap_high, s.addr_strap_low, 1'b0);
    reg_m[1] = addr_of(s.addr_strap_high, s.addr_strap_low, 1'b1);
  endtask

  task automatic link_run(input logic lw, input logic cr, input logic ao, input logic rd);
    logic [DIN_W-1:0] ew, em;
    reg_wr(8'h04, {6'h00, ao, cr});
    reg_wr(8'h0d, {3'b000, rd, 4'h0});
    i_lane_width_select = lw;
    repeat (12) @(negedge i_lvds_input_clock);
    repeat (16) begin
      @(negedge i_lvds_input_clock);
      ew = '0;
      em = '0;
      if (lw) begin
        ew[26:0] = i_lanes[26:0];
        ew[27] = rd ? i_aux_control_inputs[0] : i_lanes[27];
        ew[28] = i_aux_control_inputs[1];
      end else begin
        ew[20:0] = i_lanes[20:0];
      end
      if (cr) em[17:0] = '1;
      if (cr && lw) em[26:21] = '1;
      `CHK(o_word, ew)
      `CHK(o_crypt_mask, em)
      `CHK(o_audio_bit, ao & i_audio_or_ctrl0_input)
      `CHK(o_ctrl0_bit, ~ao & i_audio_or_ctrl0_input)
      `CHK(o_audio_crypt, ao & cr)
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    num_checks = 0;
    i_rst = 1'b1;
    i_straps = '0;
    i_lane_width_select = 1'b0;
    i_power_down_n = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    src_run = 1'b0;
    void'($urandom(40));
    repeat (20) @(negedge i_mclk);
    i_rst = 1'b0;
    src_run = 1'b1;
    cap_m = i_straps;
    reg_m[0] = 8'h80;
    reg_m[1] = 8'h90;
    reg_m[4] = 8'h02;
    reg_m[13] = 8'h00;
    repeat (10) @(negedge i_mclk);
    chk_cfg;
    reg_chk(8'h04, 8'h02);
    reg_chk(8'h0d, 8'h00);
    reg_wr(8'h00, 8'($urandom));
    reg_wr(8'h01, 8'($urandom));
    reg_wr(8'h05, 8'hff);
    reg_wr(8'h10, 8'hff);
    chk_cfg;
    reg_chk(8'h10, 8'h00);
    repeat (8) begin
      capture(strap_t'($urandom));
      chk_cfg;
      // pins wander while powered up; captured values must not
      i_straps = strap_t'($urandom);
      i_lane_width_select = 1'($urandom);
      repeat (10) @(negedge i_mclk);
      chk_cfg;
    end
    for (int k = 0; k < 16; k++) link_run(k[3], k[2], k[1], k[0]);
    finish_test;
  end

  initial begin
    #2000000;
    err_count++;
    finish_test;
  end
endmodule
